// ---- hw/lpd_consts.svh ----
// constants for the led pwm duty block: offsets, codes, reset values, timing
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH

// register byte offsets
`define LPD_OFS_PHASE_LOW   12'h000
`define LPD_OFS_PHASE_HIGH  12'h004
`define LPD_OFS_INTENS_LO   12'h008
`define LPD_OFS_INTENS_HI   12'h00C
`define LPD_OFS_INTENS_9    12'h010
`define LPD_OFS_STATUS      12'h014

// reset values
`define LPD_RST_PHASE       8'h00
`define LPD_RST_INTENS      4'h0
`define LPD_RST_NINTH       1'b0
`define LPD_RST_STEP        4'h0

// last pwm step of the cycle and the static code
`define LPD_STEP_LAST       4'hF
`define LPD_CODE_STATIC     4'hF

// output timing: 16 steps, one per 16-clock wrap of the step divider
`define LPD_STEP_NS         160
`define LPD_CLK_NS          10

`endif

// ---- hw/lpd_pkg.sv ----
// types for the led pwm duty block
package lpd_pkg;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lpd_apb_req_type;

  // apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lpd_apb_rsp_type;

  // step-divider states, one-hot
  typedef enum logic [1:0] {
    LPD_ST_HOLD = 2'b01,
    LPD_ST_RUN  = 2'b10
  } lpd_state_type;

endpackage

// ---- hw/lpd_top.sv ----
// led output pwm duty generator with apb register access, blink disabled
`timescale 1ns/10ps
`include "lpd_consts.svh"

// Notes on behaviour
// - phase 0 bit picks on-time level
// - bit clear: low for setting+1 of 16
// - bit clear, code 15: static low
// - bit set inverts duty; code 15 static off
// - full code ignores gating, glitch-free static
// - first eight phase bits share one register
// - ninth phase bit in separate register
module lpd_top #(
  parameter int NUM_OUT = 9
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // apb slave
  input  wire lpd_pkg::lpd_apb_req_type apb_req_i,
  output      lpd_pkg::lpd_apb_rsp_type apb_rsp_o,
  // master timeslot gate from the intensity sequencer
  input  wire logic                     slot_gate_i,
  // open-drain outputs: low enable means the pin sinks
  output      logic [NUM_OUT-1:0]       sink_o,
  output      logic [NUM_OUT-1:0]       sink_oe_n_o
);
  import lpd_pkg::*;

  localparam int STEP_CYC = `LPD_STEP_NS / `LPD_CLK_NS;  // clocks per pwm step
  localparam int DW       = $clog2(STEP_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]         phase_low;          // phase bits of outputs one to eight
  logic               phase_ninth;        // phase bit of the ninth output
  logic [4*NUM_OUT-1:0] intens;           // 4-bit setting per output
  lpd_apb_rsp_type    rsp;                // registered answer

  // address decode
  wire acc      = apb_req_i.psel & apb_req_i.penable;
  wire wr       = acc & apb_req_i.pwrite;
  wire hit_pl   = apb_req_i.paddr == `LPD_OFS_PHASE_LOW;
  wire hit_ph   = apb_req_i.paddr == `LPD_OFS_PHASE_HIGH;
  wire hit_il   = apb_req_i.paddr == `LPD_OFS_INTENS_LO;
  wire hit_ih   = apb_req_i.paddr == `LPD_OFS_INTENS_HI;
  wire hit_i9   = apb_req_i.paddr == `LPD_OFS_INTENS_9;
  wire hit_st   = apb_req_i.paddr == `LPD_OFS_STATUS;
  wire mapped   = hit_pl | hit_ph | hit_il | hit_ih | hit_i9 | hit_st;
  wire [7:0] wd = apb_req_i.pwdata[7:0];

  // read mux; status shows the live pin sink state
  // status reads the flopped pins, so it trails a phase write by one clock
  wire [31:0] next_rdata =
      hit_pl ? {24'h000000, phase_low} :
      hit_ph ? {31'h00000000, phase_ninth} :
      hit_il ? {16'h0000, intens[15:0]} :
      hit_ih ? {16'h0000, intens[31:16]} :
      hit_i9 ? {28'h0000000, intens[35:32]} :
      hit_st ? {23'h000000, ~sink_oe_n_o} : 32'h00000000;

  // phase writes: eight outputs switch together in one write, ninth apart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_low   <= `LPD_RST_PHASE;
      phase_ninth <= `LPD_RST_NINTH;
    end else begin
      if (wr && hit_pl) phase_low <= wd;
      if (wr && hit_ph) phase_ninth <= wd[0];
    end
  end

  // intensity writes, two settings per byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intens <= '0;
    end else begin
      if (wr && hit_il) intens[15:0]  <= apb_req_i.pwdata[15:0];
      if (wr && hit_ih) intens[31:16] <= apb_req_i.pwdata[15:0];
      if (wr && hit_i9) intens[35:32] <= apb_req_i.pwdata[3:0];
    end
  end

  // answer one cycle after setup: pready on first access cycle, zero wait
  // decoding in setup lets the answer stand in the first access cycle;
  // a slower decode would cost a wait state on every transfer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp <= '0;
    end else begin
      rsp.pready  <= apb_req_i.psel & ~apb_req_i.penable;
      rsp.pslverr <= apb_req_i.psel & ~apb_req_i.penable & ~mapped;
      rsp.prdata  <= (apb_req_i.psel & ~apb_req_i.penable) ? next_rdata : 32'h00000000;
    end
  end
  assign apb_rsp_o = rsp;

  //////////////////////////////////////////////////////////////////////////////
  // pwm step generator: 16 steps per cycle
  lpd_state_type st;
  logic [DW-1:0] div;                      // clocks within one step
  logic [3:0]    step;                     // step within the pwm cycle
  wire step_end = div == DW'(STEP_CYC - 1);

  // free running after reset; hold state through reset and for the first clock after reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st   <= LPD_ST_HOLD;
      div  <= '0;
      step <= `LPD_RST_STEP;
    end else begin
      case (st)
        LPD_ST_HOLD: begin
          st <= LPD_ST_RUN;
        end
        LPD_ST_RUN: begin
          div <= step_end ? '0 : div + 1'b1;
          if (step_end) step <= step + 4'h1;
        end
        default: begin
          st <= LPD_ST_HOLD;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-output duty decision
  wire [NUM_OUT-1:0] phase_all = {phase_ninth, phase_low};
  logic [NUM_OUT-1:0] next_sink;

  // low portion is steps 0..setting; full code is static and skips gating
  // the gate only masks the pwm on-time; a closed gate leaves a phase-set
  // output sinking, since its off portion is the on-time inverted
  function automatic logic drive_low(input logic [3:0] set, input logic [3:0] stp,
                                     input logic ph, input logic gate);
    logic on;
    on = (stp <= set) & gate;
    if (set == `LPD_CODE_STATIC) drive_low = ~ph;
    else drive_low = ph ? ~on : on;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      assign next_sink[g] = drive_low(intens[4*g +: 4], step, phase_all[g], slot_gate_i);
    end
  endgenerate

  // pins from flops so static levels stay glitch-free
  // the data level stays low: an open-drain pin only moves its enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sink_o      <= '0;
      sink_oe_n_o <= '1;
    end else begin
      sink_o      <= '0;
      sink_oe_n_o <= ~next_sink;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // most checks watch the first output; the ninth has its own pair below,
  // because it decodes from a separate setting and phase register
  a_static_low_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] == `LPD_CODE_STATIC && !phase_low[0])[*2] |=> !sink_oe_n_o[0])
    else $error("full code with phase clear did not sink");
  a_static_off_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] == `LPD_CODE_STATIC && phase_low[0])[*2] |=> sink_oe_n_o[0])
    else $error("full code with phase set drove low");
  a_duty_low_part: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] != `LPD_CODE_STATIC && !phase_low[0] && slot_gate_i && step <= intens[3:0])
    |=> !sink_oe_n_o[0])
    else $error("low portion missing");
  a_duty_high_part: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] != `LPD_CODE_STATIC && !phase_low[0] && step > intens[3:0])
    |=> sink_oe_n_o[0])
    else $error("output sinks outside its duty");
  a_inverted_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] != `LPD_CODE_STATIC && phase_low[0] && slot_gate_i && step <= intens[3:0])
    |=> sink_oe_n_o[0])
    else $error("inverted duty wrong");
  a_gate_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] == `LPD_CODE_STATIC && !slot_gate_i && !phase_low[0]) |=> !sink_oe_n_o[0])
    else $error("static output followed gating");
  a_group_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr && hit_pl) |=> phase_low == $past(wd))
    else $error("shared phase write lost");
  a_ninth_apart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr && hit_pl) |=> $stable(phase_ninth))
    else $error("ninth phase changed with the group");
  a_step_advance: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st == LPD_ST_RUN && step_end) |=> step == $past(step) + 4'h1)
    else $error("pwm step did not advance");

  // inverted duty: past the setting's steps the pin sinks whatever the gate
  a_inverted_sink: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[3:0] != `LPD_CODE_STATIC && phase_low[0] && step > intens[3:0])
    |=> !sink_oe_n_o[0])
    else $error("inverted duty did not sink");

  // ninth output decodes from its own setting and phase bit
  a_ninth_static: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[35:32] == `LPD_CODE_STATIC && !phase_ninth)[*2] |=> !sink_oe_n_o[NUM_OUT-1])
    else $error("ninth output full code did not sink");
  a_ninth_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (intens[35:32] != `LPD_CODE_STATIC && !phase_ninth && step > intens[35:32])
    |=> sink_oe_n_o[NUM_OUT-1])
    else $error("ninth output sinks outside its duty");

  // a ninth phase write lands and leaves the shared group alone
  a_ninth_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr && hit_ph) |=> phase_ninth == $past(wd[0]))
    else $error("ninth phase write lost");
  a_group_apart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr && hit_ph) |=> $stable(phase_low))
    else $error("group phase changed with the ninth");

  // zero wait states: every access cycle is answered at once
  a_ready_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (apb_req_i.psel && apb_req_i.penable) |-> rsp.pready)
    else $error("access cycle without ready");
  // unmapped addresses are refused with an error and empty data
  a_unmapped_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (acc && !mapped) |-> (rsp.pslverr && rsp.prdata == 32'h00000000))
    else $error("unmapped access not refused");
endmodule

// ---- tb/lpd_led_load.sv ----
// led loads on the open-drain outputs, with one relay sharing two of them
`timescale 1ns/10ps
module lpd_led_load (
  // pins from the block
  input  wire logic [8:0] sink_i,
  input  wire logic [8:0] sink_oe_n_i,
  // load state seen by the bench
  output      logic [8:0] led_on_o,
  output      logic       relay_on_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pull-up holds a released pin high, so an led only lights while sunk
  assign led_on_o   = ~sink_oe_n_i & ~sink_i;
  // relay needs both of the first two outputs sunk: one phase register switches both
  assign relay_on_o = led_on_o[0] & led_on_o[1];
endmodule

// ---- tb/led_output_pwm_duty_blink_off_tb_top.sv ----
// self-checking bench for the led pwm duty block
`timescale 1ns/10ps
module led_output_pwm_duty_blink_off_tb_top;
  import lpd_pkg::*;
  logic            clk_i       = 1'b0;
  logic            rst_n_i     = 1'b0;
  logic            slot_gate_i = 1'b1;
  lpd_apb_req_type apb_req_i   = '0;
  lpd_apb_rsp_type apb_rsp_o;
  logic [8:0]      sink_o, sink_oe_n_o, led_on;
  logic            relay_on;
  logic [31:0]     rd;
  logic            err;
  int              miscompares = 0;
  int              check_count = 0;

  always #5 clk_i = ~clk_i;

  lpd_top #(.NUM_OUT(9)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .slot_gate_i(slot_gate_i), .sink_o(sink_o),
    .sink_oe_n_o(sink_oe_n_o));
  lpd_led_load load (.sink_i(sink_o), .sink_oe_n_i(sink_oe_n_o), .led_on_o(led_on),
    .relay_on_o(relay_on));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    apb_req_i <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_i);
    apb_req_i.penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_i);
    end while (apb_rsp_o.pready !== 1'b1);
    rd = apb_rsp_o.prdata;
    err = apb_rsp_o.pslverr;
    apb_req_i <= '0;
    @(posedge clk_i);
  endtask

  // same code and phase bit on all nine outputs, then let the pins settle
  task automatic set_all(input logic [3:0] s, input logic p);
    apb(1'b1, 12'h008, {16'h0000, {4{s}}});
    apb(1'b1, 12'h00C, {16'h0000, {4{s}}});
    apb(1'b1, 12'h010, {28'h0000000, s});
    apb(1'b1, 12'h000, {24'h000000, {8{p}}});
    apb(1'b1, 12'h004, {31'h00000000, p});
    repeat (4) @(posedge clk_i);
  endtask

  // sinking clocks of first and ninth outputs over one 256-clock cycle
  task automatic measure(input int e);
    int c0, c8, cd;
    c0 = 0;
    c8 = 0;
    cd = 0;
    repeat (256) begin
      @(posedge clk_i);
      c0 += int'(led_on[0] === 1'b1);
      c8 += int'(led_on[8] === 1'b1);
      // all nine carry one setting, so they must agree on every clock
      cd += int'(led_on !== {9{led_on[0]}} || $isunknown(led_on));
    end
    chk("first_output on clocks", e, c0);
    chk("ninth_output on clocks", e, c8);
    chk("outputs apart or unknown clocks", 0, cd);
  endtask

  task automatic test_duty();
    logic [3:0] codes [4] = '{4'h0, 4'h7, 4'hE, 4'hF};
    int e;
    for (int p = 0; p < 2; p++) foreach (codes[i]) begin
      set_all(codes[i], p[0]);
      e = (codes[i] == 4'hF) ? 256 : (int'(codes[i]) + 1) * 16;
      measure(p == 1 ? 256 - e : e);
    end
    $display("test_duty done");
  endtask

  // gate closed: phase-clear pwm codes go dark, phase-set pwm codes sink throughout, full code stays static
  task automatic test_gate();
    slot_gate_i <= 1'b0;
    set_all(4'hE, 1'b0);
    measure(0);
    set_all(4'hF, 1'b0);
    measure(256);
    set_all(4'hF, 1'b1);
    measure(0);
    set_all(4'h7, 1'b1);
    measure(256);
    slot_gate_i <= 1'b1;
    $display("test_gate done");
  endtask

  task automatic test_group();
    set_all(4'hF, 1'b0);
    chk("relay on", 1, relay_on);
    apb(1'b1, 12'h000, 32'h000000FF);
    repeat (3) @(posedge clk_i);
    chk("sink_oe_n_o", 9'h0FF, sink_oe_n_o);
    chk("relay off", 0, relay_on);
    apb(1'b0, 12'h014, 32'h00000000);
    chk("status", 32'h00000100, rd);
    chk("mapped error", 0, err);
    apb(1'b1, 12'h004, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk("sink_oe_n_o", 9'h1FF, sink_oe_n_o);
    apb(1'b0, 12'h000, 32'h00000000);
    chk("phase readback", 32'h000000FF, rd);
    apb(1'b0, 12'h018, 32'h00000000);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    $display("test_group done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: the tests need about 3350 clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("MISMATCH watchdog expected finish seen timeout");
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    chk("sink_oe_n_o in reset", 9'h1FF, sink_oe_n_o);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    test_duty();
    test_gate();
    test_group();
    conclude();
  end
endmodule
